// *** mlp_pkg.sv ***
package mlp_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_COUNT   = 8'h44;
  localparam logic [7:0] IDX_PATTERN = 8'h45;
  localparam logic [7:0] IDX_CRC_CNT = 8'h46;
  localparam logic [7:0] IDX_TO_CNT  = 8'h47;
  localparam logic [7:0] IDX_GOOD    = 8'h48;
  localparam logic [7:0] IDX_STATUS  = 8'h49;
  localparam logic [7:0] IDX_TX_CNT  = 8'h4D;
  localparam logic [7:0] IDX_RX_CNT  = 8'h4E;
  localparam logic [7:0] IDX_ADDR0   = 8'h52;
  localparam logic [7:0] IDX_ADDR5   = 8'h57;
  localparam logic [7:0] IDX_CTRL    = 8'h60;
  localparam logic [7:0] IDX_IRQ_ST  = 8'h61;
  localparam logic [7:0] IDX_IRQ_MSK = 8'h62;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_RESET   = 8'h07;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'h64;
  localparam int         STATUS_TO_BIT = 1;
  localparam int         CTRL_START    = 0;
  localparam int         CTRL_BUSY     = 1;
  localparam int         EV_DONE       = 0;
  localparam int         EV_CRC        = 1;
  localparam int         EV_TIMEOUT    = 2;
  localparam int         EV_GOOD       = 3;
  localparam int         EV_W          = 4;

  // ----------------------------------------------------------------
  // frame layout (lengths exclude the 4-byte FCS added by the MAC)
  // ----------------------------------------------------------------
  localparam logic [10:0] LEN_SHORT = 11'h03C;
  localparam logic [10:0] LEN_LONG  = 11'h5EA;
  localparam logic [10:0] POS_SA    = 11'h006;
  localparam logic [10:0] POS_TYPE  = 11'h00C;
  localparam logic [10:0] POS_DATA  = 11'h00E;
  localparam logic [15:0] ETH_TYPE  = 16'h0800;
  localparam logic [15:0] WORD_55AA = 16'h55AA;
  localparam logic [15:0] WORD_0F0F = 16'h0F0F;
  localparam logic [15:0] WORD_FF00 = 16'hFF00;
  localparam logic [7:0]  BCAST     = 8'hFF;

  localparam logic [7:0] PAT_64_UC_55   = 8'h00;
  localparam logic [7:0] PAT_1518_UC_55 = 8'h01;
  localparam logic [7:0] PAT_64_BC_55   = 8'h02;
  localparam logic [7:0] PAT_1518_BC_55 = 8'h04;
  localparam logic [7:0] PAT_64_UC_0F   = 8'h08;
  localparam logic [7:0] PAT_1518_UC_0F = 8'h10;
  localparam logic [7:0] PAT_64_BC_0F   = 8'h20;
  localparam logic [7:0] PAT_1518_BC_0F = 8'h40;
  localparam logic [7:0] PAT_1518_BC_FF = 8'h80;

  typedef enum logic [0:0] {
    GEN_IDLE = 1'b0,
    GEN_SEND = 1'b1
  } mlp_gen_e;

  // ----------------------------------------------------------------
  // pattern decoding
  // ----------------------------------------------------------------
  function automatic logic pat_long(input logic [7:0] p);
    pat_long = (p == PAT_1518_UC_55) || (p == PAT_1518_BC_55) || (p == PAT_1518_UC_0F)
            || (p == PAT_1518_BC_0F) || (p == PAT_1518_BC_FF);
  endfunction : pat_long

  function automatic logic pat_bcast(input logic [7:0] p);
    pat_bcast = (p == PAT_64_BC_55) || (p == PAT_1518_BC_55) || (p == PAT_64_BC_0F)
             || (p == PAT_1518_BC_0F) || (p == PAT_1518_BC_FF);
  endfunction : pat_bcast

  function automatic logic [15:0] pat_word(input logic [7:0] p);
    if (p == PAT_1518_BC_FF) begin
      pat_word = WORD_FF00;
    end else if (p >= PAT_64_UC_0F) begin
      pat_word = WORD_0F0F;
    end else begin
      pat_word = WORD_55AA;
    end
  endfunction : pat_word

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction : sat_inc

endpackage : mlp_pkg

// *** mlp_frame_byte.sv ***
`timescale 1ns/1ps
`default_nettype none
module mlp_frame_byte
  import mlp_pkg::*;
(
  input  wire logic [10:0]     idx,
  input  wire logic [7:0]      pattern,
  input  wire logic [5:0][7:0] addr,
  input  wire logic [7:0]      da_last,
  output logic      [7:0]      data
);

  logic [10:0] rel;
  logic [15:0] word;

  always_comb begin
    rel  = 11'h000;
    word = pat_word(pattern);
    if (idx < POS_SA) begin
      if (pat_bcast(pattern)) begin
        data = BCAST;
      end else if (idx == POS_SA - 11'h001) begin
        data = da_last;
      end else begin
        data = addr[idx[2:0]];
      end
    end else if (idx < POS_TYPE) begin
      rel  = idx - POS_SA;
      data = addr[rel[2:0]];
    end else if (idx == POS_TYPE) begin
      data = ETH_TYPE[15:8];
    end else if (idx == POS_TYPE + 11'h001) begin
      data = ETH_TYPE[7:0];
    end else begin
      rel  = idx - POS_DATA;
      data = rel[0] ? word[7:0] : word[15:8];
    end
  end

endmodule : mlp_frame_byte
`default_nettype wire

// *** mlp_loopback_setup.sv ***
`timescale 1ns/1ps
`default_nettype none
module mlp_loopback_setup
  import mlp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        center_side,
  input  wire logic        rx_loop_good,
  input  wire logic        rx_loop_crc_err,
  input  wire logic        reply_timeout,
  input  wire logic        rx_frame_valid,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  output logic             tx_sof,
  output logic             tx_eof,
  input  wire logic        tx_ready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             waitreq;
    logic [31:0]      readdata;
    logic             irq;
    logic [7:0]       count;
    logic [7:0]       pattern;
    logic [7:0]       crc_cnt;
    logic [7:0]       to_cnt;
    logic [7:0]       good_cnt;
    logic             to_flag;
    logic [7:0]       tx_cnt;
    logic [7:0]       rx_cnt;
    logic [5:0][7:0]  addr;
    logic [EV_W-1:0]  irq_stat;
    logic [EV_W-1:0]  irq_mask;
    mlp_gen_e         st;
    logic [10:0]      byte_idx;
    logic [7:0]       frame_idx;
    logic [7:0]       da_last;
    logic [7:0]       run_pattern;
    logic             tx_valid;
    logic [7:0]       tx_data;
    logic             tx_sof;
    logic             tx_eof;
  } mlp_state_s;

  mlp_state_s r;
  mlp_state_s next_r;

  logic [7:0]  gen_byte;
  logic [7:0]  idx;
  logic        req;
  logic        acc_wr;
  logic        acc_rd;
  logic        zero_wr;
  logic        start;
  logic        frame_end;
  logic        advance;
  logic [10:0] last_idx;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] w1c;
  logic [7:0]  rd;

  mlp_frame_byte u_byte (
    .idx     (r.byte_idx),
    .pattern (r.run_pattern),
    .addr    (r.addr),
    .da_last (r.da_last),
    .data    (gen_byte)
  );

  assign avs_readdata    = r.readdata;
  assign avs_waitrequest = r.waitreq;
  assign irq             = r.irq;
  assign tx_valid        = r.tx_valid;
  assign tx_data         = r.tx_data;
  assign tx_sof          = r.tx_sof;
  assign tx_eof          = r.tx_eof;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r    = r;
    idx       = avs_address[9:2];
    req       = avs_read || avs_write;
    acc_wr    = avs_write && !r.waitreq && avs_byteenable[0];
    acc_rd    = avs_read && !r.waitreq;
    zero_wr   = acc_wr && (idx == IDX_COUNT) && (avs_writedata[7:0] == 8'h00);
    start     = acc_wr && (idx == IDX_CTRL) && avs_writedata[CTRL_START] && center_side
             && (r.st == GEN_IDLE) && (r.count != 8'h00) && (r.count <= COUNT_MAX);
    last_idx  = (pat_long(r.run_pattern) ? LEN_LONG : LEN_SHORT) - 11'h001;
    advance   = (r.st == GEN_SEND) && (!r.tx_valid || tx_ready);
    frame_end = advance && (r.byte_idx == last_idx);
    ev        = '0;
    w1c       = '0;
    rd        = 8'h00;

    // bus slave: one wait cycle, then the request is accepted
    next_r.waitreq = !(req && r.waitreq);
    case (idx)
      IDX_COUNT:   rd = r.count;
      IDX_PATTERN: rd = r.pattern;
      IDX_CRC_CNT: rd = r.crc_cnt;
      IDX_TO_CNT:  rd = r.to_cnt;
      IDX_GOOD:    rd = r.good_cnt;
      IDX_STATUS:  rd = {6'h00, r.to_flag, 1'b0};
      IDX_TX_CNT:  rd = r.tx_cnt;
      IDX_RX_CNT:  rd = r.rx_cnt;
      IDX_CTRL:    rd = {6'h00, (r.st == GEN_SEND), 1'b0};
      IDX_IRQ_ST:  rd = {4'h0, r.irq_stat};
      IDX_IRQ_MSK: rd = {4'h0, r.irq_mask};
      default: begin
        if (idx >= IDX_ADDR0 && idx <= IDX_ADDR5) begin
          rd = r.addr[3'(idx - IDX_ADDR0)];
        end else begin
          rd = 8'h00;
        end
      end
    endcase
    if (req && r.waitreq) begin
      next_r.readdata = {24'h0000_00, rd};
    end

    // register writes
    if (acc_wr) begin
      case (idx)
        IDX_COUNT:   next_r.count    = avs_writedata[7:0];
        IDX_PATTERN: next_r.pattern  = avs_writedata[7:0];
        IDX_IRQ_MSK: next_r.irq_mask = avs_writedata[EV_W-1:0];
        IDX_IRQ_ST:  w1c             = avs_writedata[EV_W-1:0];
        default: begin
          if (idx >= IDX_ADDR0 && idx <= IDX_ADDR5) begin
            next_r.addr[3'(idx - IDX_ADDR0)] = avs_writedata[7:0];
          end
        end
      endcase
    end

    // frame generator
    case (r.st)
      GEN_IDLE: begin
        if (start) begin
          next_r.st          = GEN_SEND;
          next_r.run_pattern = r.pattern;
          next_r.byte_idx    = 11'h000;
          next_r.frame_idx   = 8'h00;
          next_r.da_last     = r.addr[5] + 8'h01;
        end
        if (tx_ready) begin
          next_r.tx_valid = 1'b0;
        end
      end
      GEN_SEND: begin
        if (advance) begin
          next_r.tx_valid = 1'b1;
          next_r.tx_data  = gen_byte;
          next_r.tx_sof   = (r.byte_idx == 11'h000);
          next_r.tx_eof   = frame_end;
          next_r.byte_idx = r.byte_idx + 11'h001;
        end
        if (frame_end) begin
          next_r.byte_idx  = 11'h000;
          next_r.frame_idx = r.frame_idx + 8'h01;
          next_r.da_last   = r.da_last + 8'h01;
          next_r.tx_cnt    = sat_inc(r.tx_cnt);
          if (r.frame_idx + 8'h01 == r.count) begin
            next_r.st    = GEN_IDLE;
            ev[EV_DONE]  = 1'b1;
          end
        end
        if (zero_wr) begin
          next_r.st = GEN_IDLE;
        end
      end
      default: next_r.st = GEN_IDLE;
    endcase

    // returned frames counted on both sides, result counters center side only
    if (rx_frame_valid) begin
      next_r.rx_cnt = sat_inc(r.rx_cnt);
    end
    if (center_side && rx_loop_crc_err) begin
      next_r.crc_cnt = sat_inc(r.crc_cnt);
      ev[EV_CRC]     = 1'b1;
    end
    if (center_side && rx_loop_good) begin
      next_r.good_cnt = sat_inc(r.good_cnt);
      ev[EV_GOOD]     = 1'b1;
    end
    if (acc_rd && idx == IDX_STATUS) begin
      next_r.to_flag = 1'b0;
    end
    if (center_side && reply_timeout) begin
      next_r.to_flag = 1'b1;
      next_r.to_cnt  = sat_inc(r.to_cnt);
      ev[EV_TIMEOUT] = 1'b1;
    end

    // zero count write clears tx/rx counts, result counters center side only
    if (zero_wr) begin
      next_r.tx_cnt = 8'h00;
      next_r.rx_cnt = 8'h00;
      if (center_side) begin
        next_r.crc_cnt  = 8'h00;
        next_r.to_cnt   = 8'h00;
        next_r.good_cnt = 8'h00;
      end
    end

    // interrupt: set wins over write-one-to-clear
    next_r.irq_stat = (r.irq_stat & ~w1c) | ev;
    next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r             <= '0;
      r.waitreq     <= 1'b1;
      r.count       <= COUNT_RESET;
      r.pattern     <= PATTERN_RESET;
      r.run_pattern <= PATTERN_RESET;
      r.st          <= GEN_IDLE;
    end else begin
      r <= next_r;
    end
  end

endmodule : mlp_loopback_setup
`default_nettype wire

// *** mlp_loopback_setup_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module mlp_setup_chk
  import mlp_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        center_side,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_sof,
  input wire logic        tx_eof,
  input wire logic        tx_ready
);
  // ---------------------------------------------
  // byte position within the current frame
  // ---------------------------------------------
  logic [10:0] bcnt;
  wire         acc = tx_valid && tx_ready;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bcnt <= 11'h000;
    end else if (acc) begin
      bcnt <= tx_eof ? 11'h000 : bcnt + 11'h001;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_eof_acc;
    acc && tx_eof;
  endsequence
  sequence s_rd_acc;
    avs_read && !avs_waitrequest;
  endsequence
  a_wait_one_low: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_rd_upper: assert property (s_rd_acc |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read upper bits set");
  a_unmapped_zero: assert property ((s_rd_acc and (avs_address[9:2] == 8'h00))
    |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
    && $stable(tx_sof) && $stable(tx_eof))
    else $error("stream byte dropped");
  a_tx_center: assert property ($rose(tx_valid) |-> tx_sof && center_side)
    else $error("frame start bad");
  a_frame_len: assert property (s_eof_acc |->
    bcnt == 11'h03B || bcnt == 11'h5E9)
    else $error("frame length bad");
  a_sof_first: assert property (acc && tx_sof |-> bcnt == 11'h000)
    else $error("sof not first");
  a_type_field: assert property (acc && (bcnt == 11'h00C || bcnt == 11'h00D) |->
    tx_data == (bcnt[0] ? 8'h00 : 8'h08))
    else $error("type field bad");
  a_payload_word: assert property (acc && bcnt == 11'h00E |->
    tx_data inside {8'h55, 8'h0F, 8'hFF})
    else $error("payload start bad");
  a_eof_sof: assert property (s_eof_acc ##1 tx_valid |-> tx_sof)
    else $error("frames not contiguous");
endmodule : mlp_setup_chk
bind mlp_loopback_setup mlp_setup_chk u_chk (.sys_clk, .resetn, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .center_side, .tx_valid, .tx_data, .tx_sof,
  .tx_eof, .tx_ready);
`default_nettype wire

// *** mlp_term_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mlp_term_model (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_eof,
  input  wire logic       crc_bad,
  output logic            tx_ready,
  output logic            rx_loop_good,
  output logic            rx_loop_crc_err,
  output logic            rx_frame_valid
);
  // ---------------------------------------------
  // far side sink, stalls one cycle in three
  // ---------------------------------------------
  logic [7:0]  fbuf [0:1513];
  logic [10:0] flen;
  logic [10:0] pos;
  logic [1:0]  ph;
  int          nframes;
  assign tx_ready = (ph != 2'h2);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ph <= 2'h0;
      pos <= 11'h000;
      flen <= 11'h000;
      nframes <= 0;
      rx_loop_good <= 1'b0;
      rx_loop_crc_err <= 1'b0;
      rx_frame_valid <= 1'b0;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      rx_loop_good <= 1'b0;
      rx_loop_crc_err <= 1'b0;
      rx_frame_valid <= 1'b0;
      if (tx_valid && tx_ready) begin
        fbuf[pos] <= tx_data;
        pos <= tx_eof ? 11'h000 : pos + 11'h001;
        if (tx_eof) begin
          flen <= pos + 11'h001;
          nframes <= nframes + 1;
          rx_frame_valid <= 1'b1;
          rx_loop_good <= !crc_bad;
          rx_loop_crc_err <= crc_bad;
        end
      end
    end
  end
endmodule : mlp_term_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mlp_pkg::*;
;
  // ---------------------------------------------
  // stimulus and checks
  // ---------------------------------------------
  localparam logic [8:0] LNG = 9'h1AA;
  localparam logic [8:0] BC  = 9'h1CC;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, irq, rx_loop_good, rx_loop_crc_err, rx_frame_valid;
  logic        center_side = 1'b1;
  logic        reply_timeout = 1'b0;
  logic        crc_bad = 1'b0;
  logic        tx_valid, tx_sof, tx_eof, tx_ready;
  logic [7:0]  tx_data, rd;
  logic [7:0]  a [0:5];
  logic [7:0]  codes [0:8];
  int          errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  mlp_loopback_setup dut (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .center_side,
    .rx_loop_good, .rx_loop_crc_err, .reply_timeout, .rx_frame_valid, .tx_valid, .tx_data,
    .tx_sof, .tx_eof, .tx_ready);
  mlp_term_model p (.sys_clk, .resetn, .tx_valid, .tx_data, .tx_eof, .crc_bad, .tx_ready,
    .rx_loop_good, .rx_loop_crc_err, .rx_frame_valid);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk({8'h00, rd}, {8'h00, exp});
  endtask : rchk
  task automatic pulse_to;
    reply_timeout <= 1'b1;
    @(posedge sys_clk);
    reply_timeout <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : pulse_to
  task automatic run(input logic [7:0] n, input int i);
    int          f0;
    logic [7:0]  e;
    logic [15:0] wd;
    f0 = p.nframes;
    wd = (i < 4) ? 16'h55AA : (i < 8) ? 16'h0F0F : 16'hFF00;
    xfer(1'b1, IDX_COUNT, n);
    xfer(1'b1, IDX_PATTERN, codes[i]);
    xfer(1'b1, IDX_CTRL, 8'h01);
    rchk(IDX_CTRL, 8'h02);
    while (irq !== 1'b1) @(posedge sys_clk);
    xfer(1'b1, IDX_IRQ_ST, 8'h0F);
    chk(16'(p.nframes - f0), {8'h00, n});
    chk({5'h00, p.flen}, LNG[i] ? 16'h05EA : 16'h003C);
    for (int k = 0; k < 6; k++) begin
      e = BC[i] ? 8'hFF : (k < 5) ? a[k] : 8'(a[5] + n);
      chk({8'h00, p.fbuf[k]}, {8'h00, e});
      chk({8'h00, p.fbuf[k + 6]}, {8'h00, a[k]});
    end
    chk({p.fbuf[12], p.fbuf[13]}, 16'h0800);
    chk({p.fbuf[14], p.fbuf[15]}, wd);
    chk({p.fbuf[p.flen - 2], p.fbuf[p.flen - 1]}, wd);
  endtask : run
  initial begin
    codes = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    a = '{8'h02, 8'h13, 8'h24, 8'h35, 8'h46, 8'hF0};
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rchk(IDX_COUNT, 8'h07);
    rchk(IDX_PATTERN, 8'h00);
    rchk(8'h00, 8'h00);
    for (int k = 0; k < 6; k++) xfer(1'b1, IDX_ADDR0 + 8'(k), a[k]);
    xfer(1'b1, IDX_IRQ_MSK, 8'h01);
    run(8'h03, 0);
    for (int i = 0; i < 9; i++) run(8'h01, i);
    run(8'h64, 0);
    rchk(IDX_GOOD, 8'h70);
    crc_bad <= 1'b1;
    run(8'h02, 0);
    rchk(IDX_CRC_CNT, 8'h02);
    pulse_to();
    chk({15'h0000, irq}, 16'h0000);
    xfer(1'b1, IDX_IRQ_MSK, 8'h04);
    repeat (2) @(posedge sys_clk);
    chk({15'h0000, irq}, 16'h0001);
    xfer(1'b1, IDX_IRQ_ST, 8'h04);
    repeat (2) @(posedge sys_clk);
    chk({15'h0000, irq}, 16'h0000);
    rchk(IDX_TO_CNT, 8'h01);
    rchk(IDX_STATUS, 8'h02);
    rchk(IDX_STATUS, 8'h00);
    avs_byteenable <= 4'hE;
    xfer(1'b1, IDX_COUNT, 8'h00);
    avs_byteenable <= 4'hF;
    rchk(IDX_COUNT, 8'h02);
    rchk(IDX_TX_CNT, 8'h72);
    rchk(IDX_RX_CNT, 8'h72);
    xfer(1'b1, IDX_COUNT, 8'h00);
    rchk(IDX_CRC_CNT, 8'h00);
    rchk(IDX_TO_CNT, 8'h00);
    rchk(IDX_GOOD, 8'h00);
    rchk(IDX_TX_CNT, 8'h00);
    rchk(IDX_RX_CNT, 8'h00);
    center_side <= 1'b0;
    xfer(1'b1, IDX_COUNT, 8'h01);
    xfer(1'b1, IDX_CTRL, 8'h01);
    rchk(IDX_CTRL, 8'h00);
    pulse_to();
    repeat (20) @(posedge sys_clk);
    chk(16'(p.nframes), 16'h0072);
    rchk(IDX_TO_CNT, 8'h00);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
